//--- hw/sfp_flash_dev.sv
// flash device end: otp read, page/dual/otp program, self-timed cycle
// assumes link pins asynchronous to clk_sys, sampled through two flops
// Operation
// [R1] otp read: opcode, three address bytes, dummy
// [R2] read data shifted out on falling edges
// [R3] read address advances after each byte
// [R4] no wrap; byte 65 repeats afterwards
// [R5] otp uses only low seven address bits
// [R6] chip select high ends read anytime
// [R7] otp commands rejected while cycle runs
// [R8] program commands need write enable latch
// [R9] host holds select through whole program
// [R10] page data wraps to page start
// [R11] more than 256 bytes: last kept
// [R12] fewer bytes leave rest of page
// [R13] select must rise on byte boundary
// [R14] select rise starts timed cycle, flags
// [R15] protected pages are never programmed
// [R16] host should batch consecutive bytes
// [R17] dual program carries two bits per clock
// [R18] otp program only clears bits
// [R19] otp bytes past 65 discarded
// [R20] control byte bit 0 locks otp
// [R21] dual pairs: msb first, high on io1
// [R22] latch clear: program ignored, no cycle
// [R23] locked otp: program ignored, no cycle
//
// Design decisions made here: two-flop link sampling and the self-timed cycle length.
`timescale 1ns/1ps
module sfp_flash_dev
  import sfp_pkg::*;
#(
  parameter int PAGE_WRITE_CYCLES = `SFP_PAGE_WRITE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [2:0] blockProtect,
  output logic writeInProgress,
  output logic writeEnableLatch,
  output logic otpLocked,
  sfp_link_if.dev link
);
  sfp_dev_st_e state_q;
  logic [1:0] csS_q, sckS_q, io0S_q, io1S_q;
  logic sckD_q, csD_q;
  logic [2:0] bitCnt_q, outBit_q;
  logic [7:0] shift_q, op_q, wrPtr_q;
  logic [23:0] addr_q;
  logic [1:0] addrCnt_q;
  logic [6:0] rdAddr_q, otpCnt_q;
  logic gotData_q, cmdOnly_q, wel_q, cyc_q, cycOtp_q, io1_q;
  logic [23:0] cycCnt_q;
  logic [`SFP_MEM_AW-1:8] cycPage_q;
  sfp_byte_t mem [0:(1<<`SFP_MEM_AW)-1];
  sfp_byte_t otpMem [0:64];
  sfp_byte_t pageBuf [0:255];
  logic [255:0] valid_q;

  logic active, sckRise, sckFall, csRise, dual, byteDone;
  logic [3:0] cntSum;
  logic [7:0] newByte, outByte, statusByte;
  logic [6:0] rdIdx, protSize;
  logic isOtpRd, isOtpWr, isPage, prot, startOk;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      csS_q <= 2'h3;
      sckS_q <= 2'h0;
      io0S_q <= 2'h0;
      io1S_q <= 2'h0;
      sckD_q <= 1'b0;
      csD_q <= 1'b1;
    end else begin
      csS_q <= {csS_q[0], link.csN};
      sckS_q <= {sckS_q[0], link.sck};
      io0S_q <= {io0S_q[0], link.serialIo0};
      io1S_q <= {io1S_q[0], link.serialIo1};
      sckD_q <= sckS_q[1];
      csD_q <= csS_q[1];
    end
  end

  assign active = ~csS_q[1];
  assign sckRise = active & sckS_q[1] & ~sckD_q; // [R1]
  assign sckFall = active & ~sckS_q[1] & sckD_q;
  assign csRise = csS_q[1] & ~csD_q;
  assign isOtpRd = op_q == `SFP_OP_OTP_READ;
  assign isOtpWr = op_q == `SFP_OP_OTP_WRITE;
  assign isPage = (op_q == `SFP_OP_PAGE_WRITE) ||
                  (op_q == `SFP_OP_DUAL_PAGE_WRITE);
  assign dual = (state_q == DS_DATAIN) &&
                (op_q == `SFP_OP_DUAL_PAGE_WRITE); // [R17]
  assign cntSum = {1'b0, bitCnt_q} + (dual ? 4'h2 : 4'h1);
  assign byteDone = sckRise & cntSum[3];
  // high bit of each pair on io1, earlier bits first
  assign newByte = dual ? {shift_q[5:0], io1S_q[1], io0S_q[1]}
                        : {shift_q[6:0], io0S_q[1]}; // [R21]
  assign statusByte = {6'h00, wel_q, cyc_q};
  assign rdIdx = (rdAddr_q > `SFP_OTP_CTRL_IDX) ? `SFP_OTP_CTRL_IDX
                                                : rdAddr_q;
  assign outByte = isOtpRd ? otpMem[rdIdx] : statusByte;
  assign protSize = (blockProtect == 3'h0) ? 7'h00
                    : (7'h01 << (blockProtect - 3'h1));
  assign prot = ({1'b0, addr_q[21:16]} + protSize) >= `SFP_SECTORS;
  assign otpLocked = ~otpMem[`SFP_OTP_CTRL_IDX][`SFP_OTP_LOCK_BIT];

  // start only on byte boundary, latch set, not protected or locked
  assign startOk = csRise && state_q == DS_DATAIN && bitCnt_q == 3'h0 &&
                   gotData_q && wel_q && !cyc_q && // [R13] [R8] [R22]
                   (isPage ? !prot : !otpLocked); // [R15] [R23] [R20]

  // command, address and data framing
  always_ff @(posedge clk_sys) begin
    if (reset || !active) begin
      state_q <= DS_IDLE; // [R6]
      bitCnt_q <= 3'h0;
      shift_q <= 8'h00;
      addrCnt_q <= 2'h0;
      gotData_q <= 1'b0;
      otpCnt_q <= 7'h00;
      outBit_q <= 3'h7;
      io1_q <= 1'b0;
      if (reset) begin
        op_q <= 8'h00;
        addr_q <= 24'h000000;
        wrPtr_q <= 8'h00;
        rdAddr_q <= 7'h00;
        cmdOnly_q <= 1'b0;
      end
    end else if (state_q == DS_IDLE) begin
      state_q <= DS_CMD;
      cmdOnly_q <= 1'b0;
    end else begin
      if (sckRise) begin
        shift_q <= newByte;
        bitCnt_q <= cntSum[2:0];
        if (state_q == DS_IGNORE) begin
          cmdOnly_q <= 1'b0;
        end
      end
      if (byteDone) begin
        unique case (state_q)
          DS_CMD: begin
            op_q <= newByte;
            if (newByte == `SFP_OP_OTP_READ ||
                newByte == `SFP_OP_OTP_WRITE ||
                newByte == `SFP_OP_PAGE_WRITE ||
                newByte == `SFP_OP_DUAL_PAGE_WRITE) begin
              state_q <= cyc_q ? DS_IGNORE : DS_ADDR; // [R7]
            end else if (newByte == `SFP_OP_READ_STATUS) begin
              state_q <= DS_RDOUT;
            end else begin
              state_q <= DS_IGNORE;
              cmdOnly_q <= newByte == `SFP_OP_WRITE_ENABLE && !cyc_q;
            end
          end
          DS_ADDR: begin
            addr_q <= {addr_q[15:0], newByte};
            addrCnt_q <= addrCnt_q + 2'h1;
            if (addrCnt_q == 2'h2) begin
              state_q <= isOtpRd ? DS_DUMMY : DS_DATAIN;
              wrPtr_q <= isPage ? newByte : {1'b0, newByte[6:0]}; // [R5]
            end
          end
          DS_DUMMY: begin
            state_q <= DS_RDOUT;
            rdAddr_q <= addr_q[6:0]; // [R5]
          end
          DS_DATAIN: begin
            wrPtr_q <= wrPtr_q + 8'h01; // [R10]
            gotData_q <= 1'b1;
            if (otpCnt_q != `SFP_OTP_MAX_BYTES) begin
              otpCnt_q <= otpCnt_q + 7'h01;
            end
          end
          DS_RDOUT, DS_IGNORE: begin
          end
          default: begin
          end
        endcase
      end
      if (sckFall && state_q == DS_RDOUT) begin
        io1_q <= outByte[outBit_q]; // [R2]
        outBit_q <= outBit_q - 3'h1;
        if (outBit_q == 3'h0 && isOtpRd &&
            rdAddr_q < `SFP_OTP_CTRL_IDX) begin
          rdAddr_q <= rdAddr_q + 7'h01; // [R3] [R4]
        end
      end
    end
  end

  // data latch for page and otp programming
  always_ff @(posedge clk_sys) begin
    if (reset || (byteDone && state_q == DS_CMD && !cyc_q)) begin // [R7]
      valid_q <= '0;
    end else if (byteDone && state_q == DS_DATAIN) begin
      if (isPage) begin
        pageBuf[wrPtr_q] <= newByte; // [R11]
        valid_q[wrPtr_q] <= 1'b1; // [R12]
      end else if (otpCnt_q != `SFP_OTP_MAX_BYTES &&
                   wrPtr_q <= {1'b0, `SFP_OTP_CTRL_IDX}) begin
        pageBuf[wrPtr_q] <= newByte; // [R19]
        valid_q[wrPtr_q] <= 1'b1;
      end
    end else if (cyc_q && cycCnt_q == 24'(PAGE_WRITE_CYCLES - 1)) begin
      valid_q <= '0;
    end
  end

  // self-timed program cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cyc_q <= 1'b0;
      cycCnt_q <= 24'h000000;
      cycOtp_q <= 1'b0;
      cycPage_q <= '0;
      for (int i = 0; i < (1 << `SFP_MEM_AW); i++) begin
        mem[i] <= 8'hff;
      end
      for (int i = 0; i < 65; i++) begin
        otpMem[i] <= 8'hff;
      end
    end else if (startOk) begin
      cyc_q <= 1'b1; // [R14]
      cycCnt_q <= 24'h000000;
      cycOtp_q <= isOtpWr;
      cycPage_q <= addr_q[`SFP_MEM_AW-1:8];
    end else if (cyc_q) begin
      cycCnt_q <= cycCnt_q + 24'h000001;
      if (cycCnt_q == 24'(PAGE_WRITE_CYCLES - 1)) begin
        cyc_q <= 1'b0;
      end
      if (cycCnt_q < 24'h000100 && valid_q[cycCnt_q[7:0]]) begin
        if (cycOtp_q) begin
          otpMem[cycCnt_q[6:0]] <= otpMem[cycCnt_q[6:0]] &
                                   pageBuf[cycCnt_q[7:0]]; // [R18]
        end else begin
          mem[{cycPage_q, cycCnt_q[7:0]}] <=
            mem[{cycPage_q, cycCnt_q[7:0]}] & pageBuf[cycCnt_q[7:0]];
        end
      end
    end
  end

  // write enable latch
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wel_q <= 1'b0;
    end else if (cyc_q && cycCnt_q == 24'h0000ff) begin
      wel_q <= 1'b0; // [R14]
    end else if (csRise && cmdOnly_q && state_q == DS_IGNORE &&
                 bitCnt_q == 3'h0) begin
      wel_q <= 1'b1; // [R8]
    end
  end

  assign writeInProgress = cyc_q;
  assign writeEnableLatch = wel_q;
  assign link.devIo1 = io1_q;
  assign link.devIo1Oe = active && state_q == DS_RDOUT;
endmodule

//--- hw/sfp_cfg.svh
// constants of the serial flash program/otp link: opcodes, fields, timing
// assumes inclusion by bare name from the package and the testbench top
`ifndef SFP_CFG_SVH
`define SFP_CFG_SVH

`define SFP_OP_WRITE_ENABLE 8'h06
`define SFP_OP_READ_STATUS 8'h05
`define SFP_OP_PAGE_WRITE 8'h02
`define SFP_OP_DUAL_PAGE_WRITE 8'ha2
`define SFP_OP_OTP_READ 8'h4b
`define SFP_OP_OTP_WRITE 8'h42

`define SFP_STAT_WIP 0
`define SFP_STAT_WEL 1
`define SFP_OTP_CTRL_IDX 7'h40
`define SFP_OTP_LOCK_BIT 0
`define SFP_OTP_MAX_BYTES 7'h41
`define SFP_PAGE_BYTES 9'h100
`define SFP_MEM_AW 12
`define SFP_SECTORS 7'h40

`define SFP_CLK_PERIOD_NS 10
`define SFP_PAGE_WRITE_TIME_NS 800000
`define SFP_PAGE_WRITE_CYCLES \
  ((`SFP_PAGE_WRITE_TIME_NS + `SFP_CLK_PERIOD_NS - 1) / `SFP_CLK_PERIOD_NS)
`define SFP_SCK_HALF_LAST 3'h7

`define SFP_REG_CTRL 11'h000
`define SFP_REG_ADDR 11'h004
`define SFP_REG_STATUS 11'h008
`define SFP_REG_BUF_BIT 10
`define SFP_CTRL_GO 31
`define SFP_CTRL_LEN_LSB 8
`define SFP_CTRL_LEN_MSB 16

`endif

//--- hw/sfp_pkg.sv
// types shared by both ends of the serial flash link
// assumes sfp_cfg.svh on the include path
package sfp_pkg;
  `include "sfp_cfg.svh"

  typedef enum logic [2:0] {
    DS_IDLE = 3'b000,
    DS_CMD = 3'b001,
    DS_ADDR = 3'b010,
    DS_DUMMY = 3'b011,
    DS_RDOUT = 3'b100,
    DS_DATAIN = 3'b101,
    DS_IGNORE = 3'b110
  } sfp_dev_st_e;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_LEAD = 3'b001,
    HS_BITS = 3'b010,
    HS_TRAIL = 3'b011,
    HS_GAP = 3'b100
  } sfp_host_st_e;

  typedef logic [7:0] sfp_byte_t;
endpackage

//--- hw/sfp_link_if.sv
// serial link between host controller and flash device
// assumes io pins pulled high when nobody drives them
`timescale 1ns/1ps
interface sfp_link_if;
  logic csN;
  logic sck;
  logic hostIo0;
  logic hostIo0Oe;
  logic hostIo1;
  logic hostIo1Oe;
  logic devIo1;
  logic devIo1Oe;
  logic serialIo0;
  logic serialIo1;

  assign serialIo0 = hostIo0Oe ? hostIo0 : 1'b1;
  assign serialIo1 = devIo1Oe ? devIo1 : (hostIo1Oe ? hostIo1 : 1'b1);

  modport host(
    output csN,
    output sck,
    output hostIo0,
    output hostIo0Oe,
    output hostIo1,
    output hostIo1Oe,
    input serialIo1
  );
  modport dev(
    input csN,
    input sck,
    input serialIo0,
    input serialIo1,
    output devIo1,
    output devIo1Oe
  );
endinterface

//--- hw/sfp_host.sv
// host controller end: builds one framed transfer per software order
// assumes link pins asynchronous; returned data sampled through two flops
`timescale 1ns/1ps
module sfp_host
  import sfp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [10:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  sfp_link_if.host link
);
  sfp_host_st_e state_q;
  logic [7:0] op_q, rxShift_q;
  logic [8:0] count_q;
  logic [23:0] addr_q;
  logic [9:0] byteIdx_q;
  logic [2:0] bitIdx_q, half_q;
  logic [1:0] io1S_q;
  logic cs_q, sck_q, io0_q, io1_q, io1Oe_q;
  logic [31:0] rdData_q;
  sfp_byte_t buf_q [0:255];

  logic hasAddr, hasDummy, isRx, lastBit, goWr, fall, storeRx;
  logic [9:0] hdrLen, total, nByte;
  logic [2:0] nBit;
  logic [1:0] nPins;
  logic [7:0] nextByte;

  assign hasAddr = op_q == `SFP_OP_PAGE_WRITE ||
                   op_q == `SFP_OP_DUAL_PAGE_WRITE ||
                   op_q == `SFP_OP_OTP_READ || op_q == `SFP_OP_OTP_WRITE;
  assign hasDummy = op_q == `SFP_OP_OTP_READ; // [R1]
  assign isRx = op_q == `SFP_OP_OTP_READ || op_q == `SFP_OP_READ_STATUS;
  assign hdrLen = 10'h001 + (hasAddr ? 10'h003 : 10'h000) +
                  (hasDummy ? 10'h001 : 10'h000);
  assign total = hdrLen + {1'b0, count_q};

  function automatic logic dualAt(input logic [9:0] idx);
    dualAt = op_q == `SFP_OP_DUAL_PAGE_WRITE && idx >= hdrLen; // [R17]
  endfunction

  function automatic logic [7:0] byteAt(input logic [9:0] idx);
    logic [9:0] d;
    d = idx - hdrLen;
    if (idx == 10'h000) begin
      byteAt = op_q;
    end else if (hasAddr && idx == 10'h001) begin
      byteAt = addr_q[23:16];
    end else if (hasAddr && idx == 10'h002) begin
      byteAt = addr_q[15:8];
    end else if (hasAddr && idx == 10'h003) begin
      byteAt = addr_q[7:0];
    end else if (idx < hdrLen) begin
      byteAt = 8'h00;
    end else begin
      byteAt = buf_q[d[7:0]];
    end
  endfunction

  // next bit position after a falling edge
  // process form so opcode and buffer changes reach the pins
  always_comb begin
    lastBit = dualAt(byteIdx_q) ? bitIdx_q == 3'h1 : bitIdx_q == 3'h0;
    nByte = lastBit ? byteIdx_q + 10'h001 : byteIdx_q;
    nBit = lastBit ? 3'h7
           : bitIdx_q - (dualAt(byteIdx_q) ? 3'h2 : 3'h1);
    nextByte = byteAt(nByte);
    // pair: high bit on io1, low bit on io0
    nPins = dualAt(nByte) ? {nextByte[nBit], nextByte[nBit - 3'h1]}
                          : {1'b0, nextByte[nBit]}; // [R21]
  end
  assign fall = state_q == HS_BITS && half_q == `SFP_SCK_HALF_LAST && sck_q;
  assign storeRx = fall && lastBit && isRx && byteIdx_q >= hdrLen;
  assign goWr = regWr && regAddr == `SFP_REG_CTRL &&
                regWrData[`SFP_CTRL_GO] && state_q == HS_IDLE;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      io1S_q <= 2'h0;
    end else begin
      io1S_q <= {io1S_q[0], link.serialIo1};
    end
  end

  // software orders
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      op_q <= 8'h00;
      count_q <= 9'h000;
      addr_q <= 24'h000000;
    end else if (regWr && state_q == HS_IDLE) begin
      if (regAddr == `SFP_REG_CTRL) begin
        op_q <= regWrData[7:0];
        count_q <= regWrData[`SFP_CTRL_LEN_MSB:`SFP_CTRL_LEN_LSB];
      end else if (regAddr == `SFP_REG_ADDR) begin
        addr_q <= regWrData[23:0];
      end
    end
  end

  // data buffer: bytes to send, bytes received
  always_ff @(posedge clk_sys) begin
    if (storeRx) begin
      buf_q[8'(byteIdx_q - hdrLen)] <= rxShift_q;
    end else if (regWr && regAddr[`SFP_REG_BUF_BIT] && state_q == HS_IDLE)
    begin
      buf_q[regAddr[9:2]] <= regWrData[7:0];
    end
  end

  // transfer framing and clock divider
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= HS_IDLE;
      cs_q <= 1'b1;
      sck_q <= 1'b0;
      io0_q <= 1'b0;
      io1_q <= 1'b0;
      io1Oe_q <= 1'b0;
      half_q <= 3'h0;
      byteIdx_q <= 10'h000;
      bitIdx_q <= 3'h7;
      rxShift_q <= 8'h00;
    end else begin
      half_q <= (state_q == HS_IDLE) ? 3'h0 : half_q + 3'h1;
      unique case (state_q)
        HS_IDLE: begin
          if (goWr) begin
            state_q <= HS_LEAD;
            cs_q <= 1'b0;
            byteIdx_q <= 10'h000;
            bitIdx_q <= 3'h7;
            io0_q <= regWrData[7];
          end
        end
        HS_LEAD: begin
          if (half_q == `SFP_SCK_HALF_LAST) begin
            state_q <= HS_BITS;
          end
        end
        HS_BITS: begin
          if (half_q == `SFP_SCK_HALF_LAST) begin
            sck_q <= ~sck_q;
            if (!sck_q) begin
              rxShift_q <= {rxShift_q[6:0], io1S_q[1]};
            end else begin
              byteIdx_q <= nByte;
              bitIdx_q <= nBit;
              io0_q <= nPins[0];
              io1_q <= nPins[1];
              io1Oe_q <= dualAt(nByte) && nByte < total;
              if (nByte == total) begin
                state_q <= HS_TRAIL; // [R13]
              end
            end
          end
        end
        HS_TRAIL: begin
          if (half_q == `SFP_SCK_HALF_LAST) begin
            cs_q <= 1'b1; // [R9]
            state_q <= HS_GAP;
          end
        end
        HS_GAP: begin
          if (half_q == `SFP_SCK_HALF_LAST) begin
            state_q <= HS_IDLE;
          end
        end
        default: begin
          state_q <= HS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdData_q <= 32'h00000000;
    end else if (regRd) begin
      if (regAddr[`SFP_REG_BUF_BIT]) begin
        rdData_q <= {24'h000000, buf_q[regAddr[9:2]]};
      end else if (regAddr == `SFP_REG_STATUS) begin
        rdData_q <= {31'h00000000, state_q != HS_IDLE};
      end else if (regAddr == `SFP_REG_ADDR) begin
        rdData_q <= {8'h00, addr_q};
      end else if (regAddr == `SFP_REG_CTRL) begin
        rdData_q <= {15'h0000, count_q, op_q};
      end else begin
        rdData_q <= 32'h00000000;
      end
    end else begin
      rdData_q <= 32'h00000000;
    end
  end

  assign regRdData = rdData_q;
  assign link.csN = cs_q;
  assign link.sck = sck_q;
  assign link.hostIo0 = io0_q;
  assign link.hostIo0Oe = 1'b1;
  assign link.hostIo1 = io1_q;
  assign link.hostIo1Oe = io1Oe_q;
endmodule

//--- tb/sfp_assertions.sv
// checker beside the link between host and flash device
// assumes link signals and device flags sampled on clk_sys
`timescale 1ns/1ps
module sfp_assertions #(
  parameter int PAGE_WRITE_CYCLES = 300
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic csN,
  input wire logic sck,
  input wire logic hostIo1Oe,
  input wire logic devIo1,
  input wire logic devIo1Oe,
  input wire logic writeInProgress,
  input wire logic writeEnableLatch,
  input wire logic otpLocked
);
  logic [31:0] wipCnt_q;

  // cycles spent in the current self-timed cycle
  always_ff @(posedge clk_sys) begin
    if (reset || !writeInProgress) begin
      wipCnt_q <= 32'h0;
    end else begin
      wipCnt_q <= wipCnt_q + 32'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  chk_sck_idle_low: assert property (csN |-> !sck)
    else $error("sck moved while deselected");
  chk_out_on_low: assert property (devIo1Oe && $past(devIo1Oe)
    && $changed(devIo1) |-> !sck)
    else $error("read data changed while sck high");
  chk_out_needs_cs: assert property ($rose(devIo1Oe) |-> !csN)
    else $error("device drove io1 while deselected");
  chk_out_released: assert property (csN [*5] |-> !devIo1Oe)
    else $error("device kept io1 after deselect");
  chk_cycle_needs_wel: assert property ($rose(writeInProgress)
    |-> $past(writeEnableLatch))
    else $error("cycle started without write enable");
  chk_cycle_at_cs: assert property ($rose(writeInProgress) |-> csN)
    else $error("cycle started inside a frame");
  chk_wip_holds: assert property ($rose(writeInProgress)
    |=> writeInProgress [*8])
    else $error("cycle ended at once");
  chk_wip_length: assert property ($fell(writeInProgress)
    |-> wipCnt_q == 32'(PAGE_WRITE_CYCLES))
    else $error("cycle length wrong");
  chk_wel_before_end: assert property ($fell(writeInProgress)
    |-> !writeEnableLatch)
    else $error("write enable still set at cycle end");
  chk_lock_sticky: assert property (otpLocked |=> otpLocked)
    else $error("otp lock released");
  chk_dual_no_clash: assert property (hostIo1Oe |-> !devIo1Oe)
    else $error("both ends drive io1");

  cov_cycle: cover property ($rose(writeInProgress));
  cov_dual: cover property ($rose(hostIo1Oe));
  cov_read: cover property ($rose(devIo1Oe));
  cov_lock: cover property ($rose(otpLocked));
endmodule

//--- tb/sfp_tb_top.sv
// testbench: host and flash device joined by the link interface
// assumes host registers at the offsets of sfp_cfg.svh
`timescale 1ns/1ps
`include "sfp_cfg.svh"
module sfp_tb_top;
  import sfp_pkg::*;
  localparam int PWC = 2000;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [10:0] regAddr = 11'h000;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdData;
  logic [2:0] blockProtect = 3'h0;
  logic write_in_progress;
  logic write_enable_latch;
  logic lock;
  logic [7:0] ops [2];
  int errors = 0;
  int n_tests = 0;

  sfp_link_if link();
  sfp_host u_sfp_host(.clk_sys(clk_sys), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .link(link));
  sfp_flash_dev #(.PAGE_WRITE_CYCLES(PWC)) u_sfp_flash_dev(
    .clk_sys(clk_sys), .reset(reset), .blockProtect(blockProtect),
    .writeInProgress(write_in_progress), .writeEnableLatch(write_enable_latch), .otpLocked(lock),
    .link(link));
  sfp_assertions #(.PAGE_WRITE_CYCLES(PWC)) u_sfp_assertions(
    .clk_sys(clk_sys), .reset(reset), .csN(link.csN), .sck(link.sck),
    .hostIo1Oe(link.hostIo1Oe), .devIo1(link.devIo1),
    .devIo1Oe(link.devIo1Oe), .writeInProgress(write_in_progress),
    .writeEnableLatch(write_enable_latch), .otpLocked(lock));

  always #5 clk_sys = ~clk_sys;

  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [10:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    d = regRdData;
  endtask

  task automatic cmp8(input string w, input logic [7:0] e,
                      input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic cmp1(input string w, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %b seen %b", w, e, g);
    end
  endtask

  // one framed transfer, waits until the host is idle again
  task automatic run(input logic [7:0] op, input logic [8:0] n,
                     input logic [23:0] a);
    logic [31:0] s;
    int k;
    wr(`SFP_REG_ADDR, {8'h00, a});
    wr(`SFP_REG_CTRL, {1'b1, 14'h0000, n, op});
    s = 32'h1;
    k = 0;
    while (s[0] !== 1'b0 && k < 3000) begin
      rd(`SFP_REG_STATUS, s);
      k++;
    end
    if (k >= 3000) begin
      errors++;
      $display("[ERR] host busy expected 0 seen 1");
    end
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic putb(input int i, input logic [7:0] d);
    wr(11'h400 + 11'(4 * i), {24'h0, d});
  endtask

  task automatic getb(input int i, input logic [7:0] e);
    logic [31:0] d;
    rd(11'h400 + 11'(4 * i), d);
    cmp8("buffer byte", e, d[7:0]);
  endtask

  task automatic write_enable_cmd();
    run(`SFP_OP_WRITE_ENABLE, 9'h000, 24'h0);
  endtask

  task automatic idle();
    int k;
    k = 0;
    while (write_in_progress !== 1'b0 && k < 3000) begin
      @(posedge clk_sys);
      k++;
    end
    cmp1("cycle end", 1'b0, write_in_progress);
  endtask

  task automatic endTest(input string t);
    $display("test %s finished, mismatches so far %0d", t, errors);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #900us;
    errors++;
    $display("[ERR] run end expected done seen timeout");
    tally_and_finish();
  end

  initial begin
    ops[0] = `SFP_OP_PAGE_WRITE;
    ops[1] = `SFP_OP_DUAL_PAGE_WRITE;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    cmp1("wip", 1'b0, write_in_progress);
    cmp1("lock", 1'b0, lock);
    endTest("reset");
    putb(0, 8'h5a);
    run(`SFP_OP_PAGE_WRITE, 9'h001, 24'h000010);
    cmp1("wip", 1'b0, write_in_progress);
    endTest("no latch");
    blockProtect <= 3'h1;
    foreach (ops[j]) begin
      write_enable_cmd();
      cmp1("wel", 1'b1, write_enable_latch);
      run(ops[j], 9'h001, 24'h3f0000);
      cmp1("wip", 1'b0, write_in_progress);
    end
    blockProtect <= 3'h0;
    endTest("protected");
    foreach (ops[j]) begin
      putb(1, 8'h11);
      putb(2, 8'h22);
      write_enable_cmd();
      run(ops[j], 9'h003, 24'h0000fe);
      cmp1("wip", 1'b1, write_in_progress);
      idle();
      cmp1("wel", 1'b0, write_enable_latch);
      cmp8("byte fe", 8'h5a, u_sfp_flash_dev.mem[12'h0fe]);
      cmp8("byte ff", 8'h11, u_sfp_flash_dev.mem[12'h0ff]);
      cmp8("wrap byte", 8'h22, u_sfp_flash_dev.mem[12'h000]);
      cmp8("kept byte", 8'hff, u_sfp_flash_dev.mem[12'h001]);
    end
    endTest("program");
    putb(0, 8'ha5);
    putb(1, 8'h3c);
    write_enable_cmd();
    run(`SFP_OP_OTP_WRITE, 9'h002, 24'hffff82);
    idle();
    run(`SFP_OP_OTP_READ, 9'h004, 24'h000001);
    getb(0, 8'hff);
    getb(1, 8'ha5);
    getb(2, 8'h3c);
    getb(3, 8'hff);
    putb(0, 8'h0f);
    write_enable_cmd();
    run(`SFP_OP_OTP_WRITE, 9'h001, 24'h000002);
    idle();
    run(`SFP_OP_OTP_READ, 9'h001, 24'h000002);
    getb(0, 8'h05);
    endTest("otp");
    putb(0, 8'hfe);
    write_enable_cmd();
    run(`SFP_OP_OTP_WRITE, 9'h001, 24'h000040);
    idle();
    cmp1("lock", 1'b1, lock);
    run(`SFP_OP_OTP_READ, 9'h003, 24'h00003f);
    getb(0, 8'hff);
    getb(1, 8'hfe);
    getb(2, 8'hfe);
    putb(0, 8'h00);
    write_enable_cmd();
    run(`SFP_OP_OTP_WRITE, 9'h001, 24'h000000);
    cmp1("wip", 1'b0, write_in_progress);
    run(`SFP_OP_READ_STATUS, 9'h001, 24'h000000);
    getb(0, 8'h02);
    run(`SFP_OP_OTP_READ, 9'h001, 24'h000000);
    getb(0, 8'hff);
    endTest("lock");
    write_enable_cmd();
    run(`SFP_OP_PAGE_WRITE, 9'h001, 24'h000100);
    run(`SFP_OP_OTP_READ, 9'h001, 24'h000002);
    cmp1("wip", 1'b1, write_in_progress);
    getb(0, 8'hff);
    run(`SFP_OP_READ_STATUS, 9'h001, 24'h000000);
    getb(0, 8'h01);
    idle();
    run(`SFP_OP_OTP_READ, 9'h001, 24'h000002);
    getb(0, 8'h05);
    endTest("busy");
    tally_and_finish();
  end
endmodule
